/* File: verilog/bami_regs.vh */
// Register offsets, field positions and reset values of the byte addressable memory interface.
`ifndef BAMI_REGS_VH
`define BAMI_REGS_VH
`define BAMI_IDX_IO 4'h0
`define BAMI_IDX_B0 4'h4
`define BAMI_IDX_B1 4'h8
`define BAMI_IDX_ACC 4'hc
`define BAMI_IDX_RDT 4'hd
`define BAMI_RST_IO 32'h000000f8
`define BAMI_RST_BK_LO 32'h000f10f8
`define BAMI_RST_BK_HI 32'h000710f8
`define BAMI_DSZ_LO 16
`define BAMI_DSZ_HI 17
`define BAMI_MW_LO 18
`define BAMI_MW_HI 19
`define BAMI_ZF_BIT 20
`define BAMI_SHR_BIT 21
`define BAMI_GAP_BIT 22
`define BAMI_B0_MASK 32'h007fffff
`define BAMI_B1_MASK 32'h001fffff
`define BAMI_SZ8 2'h0
`define BAMI_SZ16 2'h1
`define BAMI_SZ32 2'h3
`define BAMI_B1_BASE 24'h900000
`define BAMI_B0_TOP 24'h800000
`define BAMI_B0_HI 24'h880000
`define BAMI_SP_IO 2'h2
`define BAMI_SP_FETCH 2'h3
`endif

/* File: verilog/bami_addr_map.v */
// Address shift and strobe byte lane mapping for one access.
`timescale 1ns/1ps
`default_nettype none
module bami_addr_map (
    input wire [23:0] int_addr,
    input wire [1:0] data_size,
    input wire [1:0] mem_width,
    input wire io_access,
    output reg [23:0] ext_addr,
    output reg [3:0] lane_en
);
`include "bami_regs.vh"
    always @* begin
        ext_addr = int_addr;
        lane_en = 4'hf;
        if (!io_access) begin
            case (data_size)
                `BAMI_SZ8: begin
                    ext_addr = {{2{int_addr[23]}}, int_addr[23:2]}; // RL17
                end
                `BAMI_SZ16: begin
                    ext_addr = {int_addr[23], int_addr[23:1]}; // RL15
                end
                default: begin
                    ext_addr = int_addr; // RL14
                end
            endcase
            case (mem_width)
                `BAMI_SZ32: begin
                    case (data_size)
                        `BAMI_SZ8: lane_en = 4'h1 << int_addr[1:0]; // RL6 RL17
                        `BAMI_SZ16: lane_en = int_addr[0] ? 4'hc : 4'h3; // RL6
                        default: lane_en = 4'hf; // RL6
                    endcase
                end
                `BAMI_SZ16: begin
                    // Lane 3 carries address bit 1 for byte data and address bit 0 otherwise; lanes 0 and 1 enable.
                    case (data_size)
                        `BAMI_SZ8: lane_en = {int_addr[1], 1'b0, ~int_addr[0], int_addr[0]} ^ 4'h0; // RL7
                        default: lane_en = {int_addr[0], 1'b0, 2'h3}; // RL7
                    endcase
                end
                default: begin
                    lane_en = {int_addr[1], int_addr[0], 2'h1}; // RL8
                end
            endcase
            if (mem_width == `BAMI_SZ16 && data_size == `BAMI_SZ8) begin
                lane_en = {int_addr[1], 1'b0, int_addr[0], ~int_addr[0]}; // RL7
            end
        end
    end
endmodule // bami_addr_map
`default_nettype wire

/* File: verilog/bami_read_fill.v */
// Sign extension or zero fill of narrow reads.
`timescale 1ns/1ps
`default_nettype none
module bami_read_fill (
    input wire [31:0] raw,
    input wire [1:0] data_size,
    input wire zero_fill,
    output reg [31:0] filled
);
`include "bami_regs.vh"
    always @* begin
        case (data_size)
            `BAMI_SZ8: filled = {{24{raw[7] & ~zero_fill}}, raw[7:0]}; // RL10
            `BAMI_SZ16: filled = {{16{raw[15] & ~zero_fill}}, raw[15:0]}; // RL10
            default: filled = raw;
        endcase
    end
endmodule // bami_read_fill
`default_nettype wire

/* File: verilog/bami_top.v */
// Bus control registers and external access sequencer of the byte addressable memory interface.
// Summary of operation
// RL1: I/O space: no byte enables, full words.
// RL2: I/O control register resets to 0f8h.
// RL3: Data size field 17:16, 10 reserved.
// RL4: Width resets 32 bits or 16 from pin.
// RL5: Width field 19:18, 10 reserved.
// RL6: 32-bit width: four lanes are byte enables.
// RL7: 16-bit width: lane 3 address, 0-1 enables.
// RL8: 8-bit width: lanes 3,2 address, one enable.
// RL9: Address lanes driven on every external access.
// RL10: Narrow reads sign-extend or zero-fill by bit 20.
// RL11: Shared lane off: bank zero low, bank one high.
// RL12: Shared lane on: bank zero also high range.
// RL13: Bit 22 inserts gap between cross-bank reads.
// RL14: 32 width, 32 size: address unchanged.
// RL15: 16 width, 16 size: shift right one.
// RL16: Bank registers reset 0f10f8h or 0710f8h.
// RL17: 8-bit data on 32 width: shift two, lane.
// RL18: Software avoids stores and loads around resizing.
// RL19: Software never programs reserved encoding 10.
`timescale 1ns/1ps
`default_nettype none
module bami_top (
    input wire clk,
    input wire rstn,
    input wire program_width_pin,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg [23:0] ext_addr,
    output reg bank_zero_strobe,
    output reg bank_one_strobe,
    output reg io_space_strobe,
    output reg [3:0] bank_zero_lanes,
    output reg [3:0] bank_one_lanes,
    output reg ext_rw,
    output reg [31:0] ext_data_out,
    output reg ext_data_oe,
    input wire [31:0] ext_data_in
);
`include "bami_regs.vh"
    localparam ST_IDLE = 2'h0;
    localparam ST_GAP = 2'h1;
    localparam ST_XFER = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [31:0] io_strobe_bus_control_reg;
    reg [31:0] bank_zero_bus_control_reg;
    reg [31:0] bank_one_bus_control_reg;
    reg [31:0] read_result_reg;
    reg [1:0] state_reg;
    reg last_bank_reg;
    reg last_was_read_reg;
    reg [23:0] acc_addr_reg;
    reg [1:0] acc_space_reg;
    reg acc_write_reg;
    reg acc_valid_reg;
    reg pin_meta_reg;
    reg pin_sync_reg;
    reg strap_done_reg;
    reg strap_step_reg;
    reg strap_arm_reg;
    reg [31:0] io_next;
    reg [31:0] b0_next;
    reg [31:0] b1_next;

    wire bank_sel = (acc_addr_reg >= `BAMI_B1_BASE);
    wire [31:0] cur_ctl = bank_sel ? bank_one_bus_control_reg : bank_zero_bus_control_reg;
    wire [1:0] cur_size = cur_ctl[`BAMI_DSZ_HI:`BAMI_DSZ_LO]; // RL3
    wire [1:0] cur_width = cur_ctl[`BAMI_MW_HI:`BAMI_MW_LO]; // RL5
    wire is_io = (acc_space_reg == `BAMI_SP_IO);
    wire [23:0] map_addr;
    wire [3:0] map_lanes;
    wire [31:0] fill_data;
    wire gap_needed = bank_zero_bus_control_reg[`BAMI_GAP_BIT] & last_was_read_reg &
        ~acc_write_reg & (last_bank_reg != bank_sel) & ~is_io;
    wire [1:0] width_now = bank_zero_bus_control_reg[`BAMI_MW_HI:`BAMI_MW_LO];
    wire [1:0] width_one = bank_one_bus_control_reg[`BAMI_MW_HI:`BAMI_MW_LO];
    wire mem_acc = ~is_io & (acc_space_reg != `BAMI_SP_FETCH);
    wire b0_range = (acc_addr_reg < `BAMI_B0_TOP) || (acc_addr_reg >= `BAMI_B0_HI);
    wire b0_own = mem_acc & ~bank_sel & b0_range; // RL11
    wire b0_hit = b0_own | (mem_acc & bank_sel & bank_zero_bus_control_reg[`BAMI_SHR_BIT]); // RL12
    wire b1_hit = mem_acc & bank_sel; // RL11
    wire [31:0] aligned_data;

    bami_addr_map u_map (
        .int_addr(acc_addr_reg),
        .data_size(is_io ? `BAMI_SZ32 : cur_size),
        .mem_width(is_io ? `BAMI_SZ32 : cur_width),
        .io_access(is_io),
        .ext_addr(map_addr),
        .lane_en(map_lanes)
    );

    bami_read_fill u_fill (
        .raw(aligned_data),
        .data_size(is_io ? `BAMI_SZ32 : cur_size),
        .zero_fill(cur_ctl[`BAMI_ZF_BIT]),
        .filled(fill_data)
    );

    // Merges a bus write into a register under the byte enables.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge[i*8 +: 8] = wd[i*8 +: 8];
                end
            end
        end
    endfunction

    // Pin levels of one bank's lanes: enables are active low, address lanes carry the
    // address itself and must not be inverted, and an unused lane rests high.
    // A bank that is not selected still drives its address lanes from the raw address.
    function [3:0] lane_drive;
        input [1:0] width;
        input [3:0] map;
        input [23:0] ia;
        input sel;
        reg [3:0] en;
        begin
            en = map & {4{sel}};
            case (width)
                `BAMI_SZ16: lane_drive = {(sel ? map[3] : ia[1]), 1'b1, ~en[1:0]}; // RL7
                `BAMI_SZ8: lane_drive = {(sel ? map[3:2] : ia[1:0]), 1'b1, ~en[0]}; // RL8
                default: lane_drive = ~en; // RL6
            endcase
        end
    endfunction

    // Brings the addressed byte or half-word of a narrow read down to bit 0 before the
    // fill stage, since the memory returns it on the data lines of its own lane.
    function [31:0] lane_align;
        input [31:0] raw;
        input [1:0] width;
        input [1:0] size;
        input [23:0] ia;
        begin
            lane_align = raw;
            case (width)
                `BAMI_SZ32: begin
                    case (size)
                        `BAMI_SZ8: lane_align = raw >> {ia[1:0], 3'h0};
                        `BAMI_SZ16: lane_align = raw >> {ia[0], 4'h0};
                        default: lane_align = raw;
                    endcase
                end
                `BAMI_SZ16: begin
                    if (size == `BAMI_SZ8) begin
                        lane_align = raw >> {ia[0], 3'h0};
                    end
                end
                default: lane_align = raw;
            endcase
        end
    endfunction

    assign aligned_data = is_io ? ext_data_in :
        lane_align(ext_data_in, cur_width, cur_size, acc_addr_reg); // RL10

    wire bus_hit = avs_write && (avs_address == `BAMI_IDX_IO || avs_address == `BAMI_IDX_B0 ||
        avs_address == `BAMI_IDX_B1);

    always @* begin
        io_next = io_strobe_bus_control_reg;
        b0_next = bank_zero_bus_control_reg;
        b1_next = bank_one_bus_control_reg;
        if (avs_write && avs_waitrequest == 1'b0) begin
            case (avs_address)
                `BAMI_IDX_IO: io_next = merge(io_strobe_bus_control_reg, avs_writedata, avs_byteenable);
                `BAMI_IDX_B0: b0_next = merge(bank_zero_bus_control_reg, avs_writedata, avs_byteenable)
                    & `BAMI_B0_MASK;
                `BAMI_IDX_B1: b1_next = merge(bank_one_bus_control_reg, avs_writedata, avs_byteenable)
                    & `BAMI_B1_MASK;
                default: io_next = io_strobe_bus_control_reg;
            endcase
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= program_width_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // The strap is taken once, on the third edge after release, when the second synchroniser
    // stage, pin_sync_reg, holds the pin and no bus control register write is on the bus; until then
    // the banks show the low-pin value. Taking it only once keeps a pin that moves in
    // mid-run from overwriting what software wrote.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            io_strobe_bus_control_reg <= `BAMI_RST_IO; // RL2
            bank_zero_bus_control_reg <= `BAMI_RST_BK_LO;
            bank_one_bus_control_reg <= `BAMI_RST_BK_LO;
            strap_done_reg <= 1'b0;
            strap_step_reg <= 1'b0;
            strap_arm_reg <= 1'b0;
        end else begin
            io_strobe_bus_control_reg <= io_next;
            strap_step_reg <= 1'b1;
            strap_arm_reg <= strap_step_reg;
            strap_done_reg <= strap_arm_reg;
            if (strap_arm_reg && !strap_done_reg && pin_sync_reg && !bus_hit) begin
                bank_zero_bus_control_reg <= `BAMI_RST_BK_HI; // RL4 RL16
                bank_one_bus_control_reg <= `BAMI_RST_BK_HI; // RL4 RL16
            end else begin
                bank_zero_bus_control_reg <= b0_next;
                bank_one_bus_control_reg <= b1_next;
            end
        end
    end

    // Access requests: the access register holds a 24-bit address and, in bits 25:24,
    // the space; bit 31 of the written word selects a write. Results land in the
    // read-data register.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            acc_addr_reg <= 24'h000000;
            acc_space_reg <= 2'h0;
            acc_write_reg <= 1'b0;
            acc_valid_reg <= 1'b0;
            last_bank_reg <= 1'b0;
            last_was_read_reg <= 1'b0;
            read_result_reg <= 32'h00000000;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            ext_addr <= 24'h000000;
            bank_zero_strobe <= 1'b1;
            bank_one_strobe <= 1'b1;
            io_space_strobe <= 1'b1;
            bank_zero_lanes <= 4'hf;
            bank_one_lanes <= 4'hf;
            ext_rw <= 1'b1;
            ext_data_out <= 32'h00000000;
            ext_data_oe <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
            if ((avs_read || avs_write) && avs_waitrequest && !acc_valid_reg) begin
                avs_waitrequest <= 1'b0;
                case (avs_address)
                    `BAMI_IDX_IO: avs_readdata <= io_strobe_bus_control_reg;
                    `BAMI_IDX_B0: avs_readdata <= bank_zero_bus_control_reg;
                    `BAMI_IDX_B1: avs_readdata <= bank_one_bus_control_reg;
                    `BAMI_IDX_RDT: avs_readdata <= read_result_reg;
                    `BAMI_IDX_ACC: avs_readdata <= {31'h0, acc_valid_reg};
                    default: avs_readdata <= 32'h00000000;
                endcase
                if (avs_write && avs_address == `BAMI_IDX_ACC) begin
                    avs_waitrequest <= 1'b1;
                    acc_addr_reg <= avs_writedata[23:0];
                    acc_space_reg <= avs_writedata[25:24];
                    acc_write_reg <= avs_writedata[31];
                    ext_data_out <= read_result_reg;
                    acc_valid_reg <= 1'b1;
                end
            end
            case (state_reg)
                ST_IDLE: begin
                    bank_zero_strobe <= 1'b1;
                    bank_one_strobe <= 1'b1;
                    io_space_strobe <= 1'b1;
                    ext_data_oe <= 1'b0;
                    if (acc_valid_reg) begin
                        state_reg <= gap_needed ? ST_GAP : ST_XFER; // RL13
                    end
                end
                ST_GAP: begin
                    state_reg <= ST_XFER; // RL13
                end
                ST_XFER: begin
                    ext_addr <= map_addr; // RL14 RL15 RL17
                    ext_rw <= ~acc_write_reg;
                    ext_data_oe <= acc_write_reg;
                    bank_zero_lanes <= lane_drive(width_now, map_lanes, acc_addr_reg, b0_hit); // RL9 RL12
                    bank_one_lanes <= lane_drive(width_one, map_lanes, acc_addr_reg, b1_hit); // RL9 RL11
                    if (is_io) begin
                        io_space_strobe <= 1'b0; // RL1
                    end
                    if (b1_hit) begin
                        bank_one_strobe <= 1'b0; // RL11
                    end
                    if (b0_own) begin
                        // In shared mode only the lanes of bank zero join a bank one access.
                        bank_zero_strobe <= 1'b0; // RL11
                    end
                    state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    if (!acc_write_reg) begin
                        read_result_reg <= is_io ? ext_data_in : fill_data; // RL1 RL10
                    end
                    last_bank_reg <= bank_sel;
                    last_was_read_reg <= ~acc_write_reg & ~is_io;
                    acc_valid_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                    // Strobes and lanes stand for exactly one cycle per access.
                    bank_zero_strobe <= 1'b1;
                    bank_one_strobe <= 1'b1;
                    io_space_strobe <= 1'b1;
                    bank_zero_lanes <= 4'hf;
                    bank_one_lanes <= 4'hf;
                    ext_data_oe <= 1'b0;
                    // The held access command is answered here; without it the master's
                    // still-raised write would be taken again as a fresh command.
                    avs_waitrequest <= 1'b0;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // bami_top
`default_nettype wire

/* File: bench/bami_monitor.sv */
// Checker of bus answers, strobes and byte lanes at the memory interface ports.
`timescale 1ns/1ps
`default_nettype none
module bami_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic bank_zero_strobe,
    input wire logic bank_one_strobe,
    input wire logic io_space_strobe,
    input wire logic [3:0] bank_zero_lanes,
    input wire logic [3:0] bank_one_lanes,
    input wire logic ext_rw,
    input wire logic ext_data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ans_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    ans_cause_a: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
        else $error("answer without a request");
    ans_bound_a: assert property ((avs_read || avs_write) |-> ##[0:20] !avs_waitrequest)
        else $error("request not answered in time");
    strb_excl_a: assert property ($onehot0({!bank_zero_strobe, !bank_one_strobe, !io_space_strobe}))
        else $error("two strobes low together");
    strb_one_a: assert property ($fell(bank_one_strobe) |=> bank_one_strobe)
        else $error("bank one strobe stuck low");
    io_lanes_a: assert property (!io_space_strobe |-> (&bank_zero_lanes[1:0]) && (&bank_one_lanes[1:0]))
        else $error("byte enable active on io access");
    b1_lane_a: assert property (!bank_one_lanes[0] |-> !bank_one_strobe)
        else $error("bank one enable outside its space");
    b0_lane_a: assert property (!bank_zero_lanes[0] |-> !bank_zero_strobe || !bank_one_strobe)
        else $error("bank zero enable outside its spaces");
    oe_read_a: assert property (ext_data_oe |-> !ext_rw)
        else $error("data driven during a read");
    cover property ($fell(io_space_strobe));
    cover property ($fell(bank_one_strobe));
    cover property (!bank_zero_lanes[0] && !bank_one_strobe);
endmodule // bami_monitor
`default_nettype wire

/* File: bench/bami_mem_model.sv */
// Behavioural static memory on the strobe spaces, answering reads with an address pattern.
`timescale 1ns/1ps
`default_nettype none
module bami_mem_model (
    input wire logic clk,
    input wire logic [23:0] ext_addr,
    input wire logic bank_zero_strobe,
    input wire logic bank_one_strobe,
    input wire logic io_space_strobe,
    input wire logic ext_rw,
    output logic [31:0] ext_data_in
);
    logic [31:0] last_q = 32'h0;
    wire logic active = !(bank_zero_strobe && bank_one_strobe && io_space_strobe) && ext_rw;
    // A released bus shows the inverse of its word of the cycle before, so a sample one cycle late cannot match by luck.
    assign ext_data_in = active ? {ext_addr[7:0] ^ 8'h3c, ext_addr[15:8], ~ext_addr[7:0],
        ext_addr[7:0] ^ 8'ha5} : ~last_q;
    always @(posedge clk) begin
        last_q <= ext_data_in;
    end
endmodule // bami_mem_model
`default_nettype wire

/* File: bench/bami_top_tb_top.sv */
// Self-checking bench of the byte addressable memory interface.
`timescale 1ns/1ps
`default_nettype none
module bami_top_tb_top;
    logic clk = 1'b0, rstn = 1'b0, pin = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [3:0] adr = 4'h0, be = 4'h0;
    logic [31:0] wd = 32'h0, rdata, din, dout;
    logic [23:0] xa;
    logic s0, s1, sio, rw, oe, wq;
    logic [3:0] l0, l1;
    int err_total = 0, n_checks = 0, cyc = 0;
    logic [31:0] seed = 32'h00017c0c;
    logic [31:0] rdq[$];
    logic [63:0] exq[$];
    logic [63:0] ex_note;
    bami_top bami_top_i (.clk(clk), .rstn(rstn), .program_width_pin(pin), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wq), .ext_addr(xa), .bank_zero_strobe(s0),
        .bank_one_strobe(s1), .io_space_strobe(sio), .bank_zero_lanes(l0), .bank_one_lanes(l1),
        .ext_rw(rw), .ext_data_out(dout), .ext_data_oe(oe), .ext_data_in(din));
    bami_mem_model bami_mem_model_i (.clk(clk), .ext_addr(xa), .bank_zero_strobe(s0),
        .bank_one_strobe(s1), .io_space_strobe(sio), .ext_rw(rw), .ext_data_in(din));
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] pat(input logic [23:0] a);
        return {a[7:0] ^ 8'h3c, a[15:8], ~a[7:0], a[7:0] ^ 8'ha5};
    endfunction
    task give_verdict();
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cmp_rd(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] readdata expected %h seen %h", e, g);
        end
    endtask
    task cmp_ext(input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
        n_checks++;
        if (((g ^ e) & m) !== 32'h0) begin
            err_total++;
            $display("[ERR] ext_addr and lanes expected %h seen %h", e, g);
        end
    endtask
    // Requests are held until the edge that samples waitrequest low.
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        be <= b;
        do @(posedge clk); while (wq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task rdreg(input logic [3:0] a, input logic [31:0] e);
        rdq.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask
    task acc(input logic [1:0] sp, input logic [23:0] a, input logic [31:0] ex,
        input logic [31:0] m, input logic [31:0] e);
        exq.push_back({m, ex});
        bus(1'b1, 4'hc, {6'h0, sp, a}, 4'hf);
        rdreg(4'hd, e);
    endtask
    always @(posedge clk) begin
        if (rd && wq === 1'b0) begin
            if (rdq.size() == 0) cmp_rd(32'h0, 32'hx);
            else cmp_rd(rdq.pop_front(), rdata);
        end
    end
    always @(posedge clk) begin
        if (rstn && !(s0 && s1 && sio)) begin
            if (exq.size() == 0) cmp_ext(32'h0, 32'hx, 32'hffffffff);
            else begin
                ex_note = exq.pop_front();
                cmp_ext(ex_note[31:0], {xa, l0, l1}, ex_note[63:32]);
            end
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        logic [23:0] a;
        logic [31:0] t, b;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        rdreg(4'h0, 32'hf8);
        rdreg(4'h4, 32'h0f10f8);
        rdreg(4'h8, 32'h0f10f8);
        rdreg(4'h2, 32'h0);
        bus(1'b1, 4'h8, 32'h00ff0000, 4'h4);
        rdreg(4'h8, 32'h1f10f8);
        bus(1'b1, 4'h8, 32'h0f10f8, 4'hf);
        repeat (4) begin
            t = xs();
            a = {4'h9, t[19:0]};
            acc(2'h0, a, {a, 8'hf0}, 32'hffffffff, pat(a));
        end
        for (int z = 0; z < 2; z++) begin
            bus(1'b1, 4'h8, z ? 32'h1c10f8 : 32'h0c10f8, 4'hf);
            for (int k = 0; k < 4; k++) begin
                b = pat(24'he41000) >> (8 * k);
                acc(2'h0, 24'h904000 + k, {24'he41000, 4'hf, ~(4'h1 << k)}, 32'hffffffff,
                    z ? {24'h0, b[7:0]} : {{24{b[7]}}, b[7:0]});
            end
        end
        bus(1'b1, 4'h8, 32'h0510f8, 4'hf);
        b = pat(24'hc80001);
        acc(2'h0, 24'h900002, {24'hc80001, 8'hf4}, 32'hffffffff, {{16{b[15]}}, b[15:0]});
        bus(1'b1, 4'h8, 32'h0f10f8, 4'hf);
        bus(1'b1, 4'h4, 32'h2f10f8, 4'hf);
        acc(2'h0, 24'h904000, {24'h904000, 8'h00}, 32'hffffffff, pat(24'h904000));
        bus(1'b1, 4'h4, 32'h4f10f8, 4'hf);
        acc(2'h0, 24'h880010, {24'h880010, 8'h0f}, 32'hffffffff, pat(24'h880010));
        acc(2'h0, 24'h901000, {24'h901000, 8'hf0}, 32'hffffffff, pat(24'h901000));
        acc(2'h2, 24'h000040, {24'h000040, 8'hff}, 32'hffffffff, pat(24'h000040));
        exq.push_back({32'hffffffff, 24'h000100, 8'h0f});
        bus(1'b1, 4'hc, {8'h80, 24'h000100}, 4'hf);
        pin <= 1'b1;
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        rdreg(4'h4, 32'h0710f8);
        rdreg(4'h8, 32'h0710f8);
        give_verdict();
    end
endmodule // bami_top_tb_top
bind bami_top bami_monitor bami_monitor_i (.clk(clk), .rstn(rstn), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .bank_zero_strobe(bank_zero_strobe), .bank_one_strobe(bank_one_strobe),
    .io_space_strobe(io_space_strobe), .bank_zero_lanes(bank_zero_lanes),
    .bank_one_lanes(bank_one_lanes), .ext_rw(ext_rw), .ext_data_oe(ext_data_oe));
`default_nettype wire
